// file: logic/mpv_pkg.sv
// package for the pause flow control and extended vlan offload block
// assumes one 50 MHz clock, byte-wide streams and a plain register port
//
// Behaviour
// [RQ1] a write to the tx pause register with tx pause enabled sends a pause frame
// [RQ2] a pending pause frame waits until the frame in progress has ended
// [RQ3] pause requests are sent even while the transmitter is itself paused
// [RQ4] transmitted pause destination address comes from the two rx config words
// [RQ5] good rx frames: address against pause and unicast, type 0x8808, opcode 0x0001
// [RQ6] failed type/opcode or rx flow control off: frame ignored and forwarded
// [RQ7] valid pause frame halts tx for its value, raises reject, is not forwarded
// [RQ8] new pause frame while paused overwrites remaining count, zero ends the pause
// [RQ9] basic vlan mode recognises tpid 0x8100 and lets good tagged frames pass
// [RQ10] extended vlan works only when built in and the new-functions bit is set
// [RQ11] basic vlan off keeps 1518 byte limit, other tpids never recognised by core
// [RQ12] basic vlan adds 4 bytes only; longer multi-tag frames dropped unless jumbo
// [RQ13] software using extended vlan sets jumbo mode and clears basic vlan mode
// [RQ14] tagged frames found by comparing type with shared programmable tpids
// [RQ15] 12-bit vid indexes the vlan table, the replacement vid goes into the frame
// [RQ16] only the outermost tag identifier is translated
// [RQ17] software fills untranslated table entries with their own index
// [RQ18] user side avoids in-band fcs while translation is active
// [RQ19] rx filtering and validation come before the vlan check; fcs strip required
// [RQ20] rx vlan frames with strip on lose the fcs but keep their pad bytes
// [RQ21] a tag is four bytes inserted at the type position, frame grows by four
// [RQ22] tagging adds exactly one tag, never counting the tags already present
// [RQ23] run-time field picks none, all, tagged only, or tagged selected by vid
// [RQ24] rx pause address is the fixed value 0x0100 00C2 8001
// [RQ25] pause counts quanta of 512 bit times at link speed down to zero
// [RQ26] sent pause frame: type 0x8808, opcode 0x0001, value, padded to minimum
package mpv_pkg;
	localparam int MPV_AW = 8;
	// register byte offsets
	localparam logic [7:0] MPV_OFS_FLOW_CTRL_CONFIG = 8'h00;
	localparam logic [7:0] MPV_OFS_RX_CONFIG_WORD_ZERO = 8'h04;
	localparam logic [7:0] MPV_OFS_RX_CONFIG_WORD_ONE = 8'h08;
	localparam logic [7:0] MPV_OFS_TX_PAUSE = 8'h0C;
	localparam logic [7:0] MPV_OFS_CTRL = 8'h10;
	localparam logic [7:0] MPV_OFS_TPID_ZERO = 8'h14;
	localparam logic [7:0] MPV_OFS_TPID_ONE = 8'h18;
	localparam logic [7:0] MPV_OFS_TX_TAG = 8'h1C;
	localparam logic [7:0] MPV_OFS_TBL_INDEX = 8'h20;
	localparam logic [7:0] MPV_OFS_TBL_DATA = 8'h24;
	localparam logic [7:0] MPV_OFS_STATUS = 8'h28;
	localparam logic [7:0] MPV_OFS_PAUSE_LEFT = 8'h2C;
	// field positions
	localparam int MPV_FLOW_TX_PAUSE_BIT = 30;
	localparam int MPV_FLOW_RX_FC_BIT = 29;
	localparam int MPV_CW1_JUMBO_BIT = 30;
	localparam int MPV_CW1_STRIP_BIT = 29;
	localparam int MPV_CW1_BASIC_VLAN_BIT = 27;
	localparam int MPV_CTRL_NEWFN_BIT = 11;
	localparam int MPV_CTRL_TAG_MODE_LSB = 14;
	localparam int MPV_CTRL_TX_XLATE_BIT = 16;
	localparam int MPV_CTRL_RX_XLATE_BIT = 17;
	localparam int MPV_CTRL_SPEED_LSB = 20;
	localparam int MPV_STAT_PAUSED_BIT = 0;
	localparam int MPV_STAT_PEND_BIT = 1;
	localparam int MPV_STAT_REJECT_BIT = 28;
	localparam int MPV_TBL_TAG_BIT = 12;
	// reset values
	localparam logic [31:0] MPV_RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] MPV_RST_TPID_ZERO = 32'h9100_8100;
	localparam logic [31:0] MPV_RST_TPID_ONE = 32'h88A8_9200;
	// frame constants
	localparam logic [47:0] MPV_PAUSE_DA = 48'h0100_00C2_8001;
	localparam logic [15:0] MPV_PAUSE_TYPE = 16'h8808;
	localparam logic [15:0] MPV_PAUSE_OPCODE = 16'h0001;
	localparam logic [15:0] MPV_BASIC_TPID = 16'h8100;
	localparam logic [13:0] MPV_MAX_NORMAL = 14'd1518;
	localparam logic [13:0] MPV_VLAN_EXTRA = 14'd4;
	localparam logic [5:0] MPV_TAG_OFS = 6'd12;
	localparam logic [5:0] MPV_PAUSE_LEN = 6'd60;
	// pause quantum timing at each speed code
	localparam int MPV_CLK_NS = 20;
	localparam int MPV_QUANTUM_BITS = 512;
	localparam int MPV_BIT_NS_10M = 100;
	localparam int MPV_BIT_NS_100M = 10;
	localparam int MPV_BIT_NS_1G = 1;
	localparam logic [11:0] MPV_QCYC_10M =
		12'((MPV_QUANTUM_BITS * MPV_BIT_NS_10M + MPV_CLK_NS - 1) / MPV_CLK_NS);
	localparam logic [11:0] MPV_QCYC_100M =
		12'((MPV_QUANTUM_BITS * MPV_BIT_NS_100M + MPV_CLK_NS - 1) / MPV_CLK_NS);
	localparam logic [11:0] MPV_QCYC_1G =
		12'((MPV_QUANTUM_BITS * MPV_BIT_NS_1G + MPV_CLK_NS - 1) / MPV_CLK_NS);
	typedef enum logic [5:0] {
		MPV_TX_IDLE = 6'b000001,
		MPV_TX_HEAD = 6'b000010,
		MPV_TX_GRAB = 6'b000100,
		MPV_TX_EMIT = 6'b001000,
		MPV_TX_BODY = 6'b010000,
		MPV_TX_PAUSE = 6'b100000
	} mpv_tx_e;
endpackage

// file: logic/mpv_core.sv
// pause frame flow control plus vlan translation and tagging
// assumes same-clock byte streams; downstream mac core appends the fcs
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
module mpv_core #(
	parameter int TBL_DEPTH = 4096,
	parameter logic [1:0] TX_VLAN_BUILD_OPTIONS = 2'b11,
	parameter logic [0:0] RX_VLAN_BUILD_OPTIONS = 1'b1
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic [mpv_pkg::MPV_AW-1:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	input wire logic [7:0] TX_IN_DATA,
	input wire logic TX_IN_VALID,
	input wire logic TX_IN_LAST,
	output logic TX_IN_READY,
	output logic [7:0] TX_OUT_DATA,
	output logic TX_OUT_VALID,
	output logic TX_OUT_LAST,
	input wire logic [7:0] RX_IN_DATA,
	input wire logic RX_IN_VALID,
	input wire logic RX_IN_LAST,
	input wire logic RX_IN_GOOD,
	output logic [7:0] RX_OUT_DATA,
	output logic RX_OUT_VALID,
	output logic RX_OUT_LAST,
	output logic RX_OUT_BAD,
	output logic RX_REJECT,
	output logic TX_PAUSED
);
	import mpv_pkg::*;
	localparam int TBL_AW = $clog2(TBL_DEPTH);

	logic [31:0] flow_q, cw0_q, cw1_q, ctrl_q, tpid0_q, tpid1_q, tag_q;
	logic [15:0] pause_val_q;
	logic [TBL_AW-1:0] tbl_idx_q;
	logic [12:0] tbl_q [TBL_DEPTH];
	logic reject_sticky_q, pend_q, pend_d;
	logic [15:0] quanta_q;
	logic [11:0] sub_q, qcyc;
	logic rx_hit;
	mpv_tx_e st_q, st_d;

	// tpid comparison shared by both paths
	function automatic logic tpid_match(input logic [15:0] t, input logic [31:0] w0,
		input logic [31:0] w1);
		tpid_match = (t == w0[15:0]) || (t == w0[31:16]) || (t == w1[15:0]) ||
			(t == w1[31:16]);
	endfunction

	// pause frame byte by position, address bytes stored low byte first
	function automatic logic [7:0] pause_byte(input logic [5:0] i, input logic [47:0] a,
		input logic [15:0] v);
		logic [5:0] j;
		j = (i >= 6'd6) ? 6'(i - 6'd6) : i;
		if (i < 6'd12)
			pause_byte = a[8*j +: 8];
		else if (i == 6'd12)
			pause_byte = MPV_PAUSE_TYPE[15:8];
		else if (i == 6'd13)
			pause_byte = MPV_PAUSE_TYPE[7:0];
		else if (i == 6'd14)
			pause_byte = MPV_PAUSE_OPCODE[15:8];
		else if (i == 6'd15)
			pause_byte = MPV_PAUSE_OPCODE[7:0];
		else if (i == 6'd16)
			pause_byte = v[15:8];
		else if (i == 6'd17)
			pause_byte = v[7:0];
		else
			pause_byte = 8'h00;
	endfunction

	wire newfn = ctrl_q[MPV_CTRL_NEWFN_BIT]; // RQ10
	wire pause_wr = REG_WR && (REG_ADDR == MPV_OFS_TX_PAUSE);

	// software registers
	always_ff @(posedge CLK) begin
		if (RESET) begin
			flow_q <= MPV_RST_ZERO;
			cw0_q <= MPV_RST_ZERO;
			cw1_q <= MPV_RST_ZERO;
			ctrl_q <= MPV_RST_ZERO;
			tpid0_q <= MPV_RST_TPID_ZERO;
			tpid1_q <= MPV_RST_TPID_ONE;
			tag_q <= MPV_RST_ZERO;
			pause_val_q <= MPV_RST_ZERO[15:0];
			tbl_idx_q <= '0;
		end else if (REG_WR) begin
			case (REG_ADDR)
				MPV_OFS_FLOW_CTRL_CONFIG: flow_q <= REG_WDATA;
				MPV_OFS_RX_CONFIG_WORD_ZERO: cw0_q <= REG_WDATA;
				MPV_OFS_RX_CONFIG_WORD_ONE: cw1_q <= REG_WDATA;
				MPV_OFS_TX_PAUSE: pause_val_q <= REG_WDATA[15:0];
				MPV_OFS_CTRL: ctrl_q <= REG_WDATA;
				MPV_OFS_TPID_ZERO: tpid0_q <= REG_WDATA;
				MPV_OFS_TPID_ONE: tpid1_q <= REG_WDATA;
				MPV_OFS_TX_TAG: tag_q <= REG_WDATA;
				MPV_OFS_TBL_INDEX: tbl_idx_q <= REG_WDATA[TBL_AW-1:0];
				default: ;
			endcase
		end
	end

	// vlan table; reset to identity so unwritten entries pass unchanged
	for (genvar g = 0; g < TBL_DEPTH; g++) begin : g_tbl
		always_ff @(posedge CLK) begin
			if (RESET)
				tbl_q[g] <= {1'b0, 12'(g)};
			else if (REG_WR && REG_ADDR == MPV_OFS_TBL_DATA && tbl_idx_q == TBL_AW'(g))
				tbl_q[g] <= REG_WDATA[12:0]; // RQ15
		end
	end

	// reject flag: set wins over the write-one clear
	always_ff @(posedge CLK) begin
		if (RESET)
			reject_sticky_q <= 1'b0;
		else
			reject_sticky_q <= rx_hit || (reject_sticky_q && !(REG_WR &&
				REG_ADDR == MPV_OFS_STATUS && REG_WDATA[MPV_STAT_REJECT_BIT]));
	end

	// read data valid for exactly one cycle after the strobe
	always_ff @(posedge CLK) begin
		if (RESET || !REG_RD)
			REG_RDATA <= 32'h0000_0000;
		else begin
			case (REG_ADDR)
				MPV_OFS_FLOW_CTRL_CONFIG: REG_RDATA <= flow_q;
				MPV_OFS_RX_CONFIG_WORD_ZERO: REG_RDATA <= cw0_q;
				MPV_OFS_RX_CONFIG_WORD_ONE: REG_RDATA <= cw1_q;
				MPV_OFS_TX_PAUSE: REG_RDATA <= {16'h0000, pause_val_q};
				MPV_OFS_CTRL: REG_RDATA <= ctrl_q;
				MPV_OFS_TPID_ZERO: REG_RDATA <= tpid0_q;
				MPV_OFS_TPID_ONE: REG_RDATA <= tpid1_q;
				MPV_OFS_TX_TAG: REG_RDATA <= tag_q;
				MPV_OFS_TBL_INDEX: REG_RDATA <= 32'(tbl_idx_q);
				MPV_OFS_TBL_DATA: REG_RDATA <= {19'h00000, tbl_q[tbl_idx_q]};
				MPV_OFS_STATUS: REG_RDATA <= {3'h0, reject_sticky_q, 26'h0000000, pend_q,
					TX_PAUSED};
				MPV_OFS_PAUSE_LEFT: REG_RDATA <= {16'h0000, quanta_q};
				default: REG_RDATA <= 32'h0000_0000;
			endcase
		end
	end

	// ---------------- receive path ----------------
	logic [7:0] p_data [4];
	logic [3:0] p_val, p_last, p_bad;
	logic [13:0] rx_idx_q;
	logic [2:0] flush_q;
	logic da_pause_q, da_uc_q, type_ok_q, op_ok_q, v8100_q;
	logic [15:0] param_q;
	wire rx_end = RX_IN_VALID && RX_IN_LAST;
	wire strip = cw1_q[MPV_CW1_STRIP_BIT];
	wire [47:0] station = {cw1_q[15:0], cw0_q};
	wire [2:0] di = rx_idx_q[2:0];
	wire da_p = da_pause_q && (RX_IN_DATA == MPV_PAUSE_DA[8*di +: 8]); // RQ24
	wire da_u = da_uc_q && (RX_IN_DATA == station[8*di +: 8]);
	// basic mode stretches the limit only for 0x8100 frames, jumbo lifts it
	wire [13:0] rx_limit = (cw1_q[MPV_CW1_BASIC_VLAN_BIT] && v8100_q) ?
		MPV_MAX_NORMAL + MPV_VLAN_EXTRA : MPV_MAX_NORMAL; // RQ9 RQ11 RQ12
	wire too_long = !cw1_q[MPV_CW1_JUMBO_BIT] && (rx_idx_q >= rx_limit);
	assign rx_hit = rx_end && RX_IN_GOOD && (da_pause_q || da_uc_q) && type_ok_q &&
		op_ok_q && flow_q[MPV_FLOW_RX_FC_BIT] && (rx_idx_q >= 14'd18); // RQ5 RQ7
	wire rx_bad = !RX_IN_GOOD || too_long || rx_hit; // RQ6
	wire rx_xlate = RX_VLAN_BUILD_OPTIONS[0] && newfn && ctrl_q[MPV_CTRL_RX_XLATE_BIT] &&
		RX_IN_VALID && rx_idx_q == 14'd15 && tpid_match({p_data[2], p_data[1]}, tpid0_q,
		tpid1_q); // RQ14 RQ19
	wire [11:0] rx_vid = {p_data[0][3:0], RX_IN_DATA};
	wire [12:0] rx_ent = tbl_q[rx_vid[TBL_AW-1:0]];

	// header checks, made while the frame streams in
	always_ff @(posedge CLK) begin
		if (RESET || rx_end) begin
			rx_idx_q <= 14'd0;
			{da_pause_q, da_uc_q} <= 2'b11;
			{type_ok_q, op_ok_q, v8100_q} <= 3'b000;
			param_q <= 16'h0000;
		end else if (RX_IN_VALID) begin
			if (rx_idx_q != 14'h3FFF)
				rx_idx_q <= rx_idx_q + 14'd1;
			if (rx_idx_q < 14'd6)
				{da_pause_q, da_uc_q} <= {da_p, da_u};
			if (rx_idx_q == 14'd13) begin
				type_ok_q <= {p_data[0], RX_IN_DATA} == MPV_PAUSE_TYPE;
				v8100_q <= {p_data[0], RX_IN_DATA} == MPV_BASIC_TPID;
			end
			if (rx_idx_q == 14'd15)
				op_ok_q <= {p_data[0], RX_IN_DATA} == MPV_PAUSE_OPCODE;
			if (rx_idx_q == 14'd16 || rx_idx_q == 14'd17)
				param_q <= {param_q[7:0], RX_IN_DATA};
		end
	end

	// four byte delay line: holds the fcs for stripping and the outer vid
	always_ff @(posedge CLK) begin
		if (RESET) begin
			p_val <= 4'h0;
			p_last <= 4'h0;
			p_bad <= 4'h0;
			flush_q <= 3'd0;
			for (int i = 0; i < 4; i++)
				p_data[i] <= 8'h00;
			{RX_OUT_DATA, RX_OUT_VALID, RX_OUT_LAST, RX_OUT_BAD} <= 11'h000;
		end else if (RX_IN_VALID || flush_q != 3'd0) begin
			RX_OUT_DATA <= p_data[3];
			RX_OUT_VALID <= p_val[3];
			for (int i = 1; i < 4; i++)
				p_data[i] <= p_data[i-1];
			p_data[0] <= RX_IN_DATA;
			if (rx_xlate) begin
				p_data[1] <= {p_data[0][7:4], rx_ent[11:8]}; // RQ15 RQ16
				p_data[0] <= rx_ent[7:0];
			end
			if (rx_end && strip) begin
				// check field dropped, pad kept since type holds a tag
				RX_OUT_LAST <= 1'b1; // RQ20
				RX_OUT_BAD <= rx_bad;
				{p_val, p_last, p_bad} <= 12'h000;
				flush_q <= 3'd0;
			end else begin
				RX_OUT_LAST <= p_last[3];
				RX_OUT_BAD <= p_bad[3];
				p_val <= {p_val[2:0], RX_IN_VALID};
				p_last <= {p_last[2:0], rx_end};
				p_bad <= {p_bad[2:0], rx_end && rx_bad};
				flush_q <= rx_end ? 3'd4 : (flush_q == 3'd0 ? 3'd0 : 3'(flush_q - 3'd1));
			end
		end else begin
			{RX_OUT_VALID, RX_OUT_LAST, RX_OUT_BAD} <= 3'b000;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET)
			RX_REJECT <= 1'b0;
		else
			RX_REJECT <= rx_hit; // RQ7
	end

	// ---------------- pause timer ----------------
	always_comb begin
		case (ctrl_q[MPV_CTRL_SPEED_LSB +: 2])
			2'b00: qcyc = MPV_QCYC_10M;
			2'b01: qcyc = MPV_QCYC_100M;
			default: qcyc = MPV_QCYC_1G;
		endcase
	end

	// a new pause frame overwrites what is left, zero included
	always_ff @(posedge CLK) begin
		if (RESET) begin
			quanta_q <= 16'h0000;
			sub_q <= 12'h000;
			TX_PAUSED <= 1'b0;
		end else begin
			if (rx_hit) begin
				quanta_q <= param_q; // RQ8
				sub_q <= 12'(qcyc - 12'd1);
			end else if (quanta_q != 16'h0000) begin
				sub_q <= (sub_q == 12'h000) ? 12'(qcyc - 12'd1) : 12'(sub_q - 12'd1);
				if (sub_q == 12'h000)
					quanta_q <= 16'(quanta_q - 16'd1); // RQ25
			end
			TX_PAUSED <= rx_hit ? (param_q != 16'h0000) :
				!(quanta_q == 16'h0001 && sub_q == 12'h000) && quanta_q != 16'h0000;
		end
	end

	// ---------------- transmit path ----------------
	logic [5:0] cnt_q;
	logic [7:0] hold_q [4];
	logic [2:0] hold_n_q;
	logic hold_last_q;
	logic [7:0] o_data_d;
	logic o_val_d, o_last_d;
	wire tx_xfer = TX_IN_VALID && TX_IN_READY;
	wire tx_tagged = hold_n_q >= 3'd2 && tpid_match({hold_q[0], hold_q[1]}, tpid0_q,
		tpid1_q); // RQ14
	wire [11:0] tx_vid = {hold_q[2][3:0], hold_q[3]};
	wire [12:0] tx_ent = tbl_q[tx_vid[TBL_AW-1:0]];
	wire tx_xlate = TX_VLAN_BUILD_OPTIONS[0] && newfn && ctrl_q[MPV_CTRL_TX_XLATE_BIT] &&
		tx_tagged && hold_n_q == 3'd4; // RQ10 RQ16
	logic ins;
	always_comb begin
		case (ctrl_q[MPV_CTRL_TAG_MODE_LSB +: 2]) // RQ23
			2'b00: ins = 1'b0;
			2'b01: ins = 1'b1;
			2'b10: ins = tx_tagged;
			default: ins = tx_tagged && hold_n_q == 3'd4 && tx_ent[MPV_TBL_TAG_BIT];
		endcase
		ins = ins && TX_VLAN_BUILD_OPTIONS[1] && newfn; // RQ10 RQ22
	end
	wire [3:0] e_total = {ins, 2'b00} + {1'b0, hold_n_q}; // RQ21
	wire [5:0] k = ins ? 6'(cnt_q - 6'd4) : cnt_q;

	// next state and output byte
	always_comb begin
		st_d = st_q;
		o_val_d = 1'b0;
		o_last_d = 1'b0;
		o_data_d = 8'h00;
		case (st_q)
			MPV_TX_IDLE: begin
				if (pend_q)
					st_d = MPV_TX_PAUSE; // RQ2 RQ3
				else if (TX_IN_VALID && !TX_PAUSED)
					st_d = MPV_TX_HEAD; // RQ7
			end
			MPV_TX_HEAD, MPV_TX_BODY: begin
				if (tx_xfer) begin
					o_val_d = 1'b1;
					o_data_d = TX_IN_DATA;
					o_last_d = TX_IN_LAST;
					if (TX_IN_LAST)
						st_d = MPV_TX_IDLE;
					else if (st_q == MPV_TX_HEAD && cnt_q == MPV_TAG_OFS - 6'd1)
						st_d = MPV_TX_GRAB;
				end
			end
			MPV_TX_GRAB: begin
				if (tx_xfer && (TX_IN_LAST || cnt_q == 6'd3))
					st_d = MPV_TX_EMIT;
			end
			MPV_TX_EMIT: begin
				o_val_d = 1'b1;
				if (ins && cnt_q < 6'd4)
					o_data_d = tag_q[8*(3-cnt_q[1:0]) +: 8]; // RQ21
				else if (tx_xlate && k == 6'd2)
					o_data_d = {hold_q[2][7:4], tx_ent[11:8]}; // RQ15
				else if (tx_xlate && k == 6'd3)
					o_data_d = tx_ent[7:0];
				else
					o_data_d = hold_q[k[1:0]];
				if (cnt_q == 6'(e_total - 4'd1)) begin
					o_last_d = hold_last_q;
					st_d = hold_last_q ? MPV_TX_IDLE : MPV_TX_BODY;
				end
			end
			MPV_TX_PAUSE: begin
				o_val_d = 1'b1;
				o_data_d = pause_byte(cnt_q, station, pause_val_q); // RQ4 RQ26
				if (cnt_q == MPV_PAUSE_LEN - 6'd1) begin
					o_last_d = 1'b1;
					st_d = MPV_TX_IDLE;
				end
			end
			default: st_d = MPV_TX_IDLE;
		endcase
	end

	// request is kept until the idle point; a new write wins over the clear
	assign pend_d = (pause_wr && flow_q[MPV_FLOW_TX_PAUSE_BIT]) ||
		(pend_q && st_q != MPV_TX_IDLE); // RQ1 RQ2

	always_ff @(posedge CLK) begin
		if (RESET) begin
			st_q <= MPV_TX_IDLE;
			pend_q <= 1'b0;
			cnt_q <= 6'd0;
			TX_IN_READY <= 1'b0;
			{TX_OUT_DATA, TX_OUT_VALID, TX_OUT_LAST} <= 10'h000;
		end else begin
			st_q <= st_d;
			pend_q <= pend_d;
			TX_IN_READY <= st_d == MPV_TX_HEAD || st_d == MPV_TX_GRAB || st_d == MPV_TX_BODY;
			TX_OUT_DATA <= o_data_d;
			TX_OUT_VALID <= o_val_d;
			TX_OUT_LAST <= o_last_d;
			if (st_d != st_q)
				cnt_q <= 6'd0;
			else if (tx_xfer || st_q == MPV_TX_EMIT || st_q == MPV_TX_PAUSE)
				cnt_q <= (st_q == MPV_TX_BODY) ? cnt_q : 6'(cnt_q + 6'd1);
		end
	end

	// four header bytes held while the tag decision is made
	always_ff @(posedge CLK) begin
		if (RESET) begin
			hold_n_q <= 3'd0;
			hold_last_q <= 1'b0;
			for (int i = 0; i < 4; i++)
				hold_q[i] <= 8'h00;
		end else if (st_q == MPV_TX_GRAB && tx_xfer) begin
			hold_q[cnt_q[1:0]] <= TX_IN_DATA;
			hold_n_q <= 3'(cnt_q + 6'd1);
			hold_last_q <= TX_IN_LAST;
		end
	end

	// ---------------- checks ----------------
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	sequence pause_first_s;
		st_q == MPV_TX_PAUSE && cnt_q == 6'd0;
	endsequence
	pause_start_a: assert property (st_q == MPV_TX_IDLE && pend_q |=> pause_first_s) // RQ1
		else $error("pending pause did not start");
	no_cut_a: assert property ($rose(st_q == MPV_TX_PAUSE) |-> $past(st_q) == MPV_TX_IDLE) // RQ2
		else $error("pause frame cut into a frame");
	paused_send_a: assert property (TX_PAUSED && pend_q && st_q == MPV_TX_IDLE // RQ3
		|=> st_q == MPV_TX_PAUSE) else $error("pause request lost while paused");
	pause_da_a: assert property (pause_first_s |=> TX_OUT_VALID && TX_OUT_DATA == cw0_q[7:0]
		##1 TX_OUT_DATA == cw0_q[15:8]) else $error("pause address wrong"); // RQ4
	reject_load_a: assert property (rx_hit |=> RX_REJECT && quanta_q == // RQ8
		$past(param_q)) else $error("pause value not loaded");
	ignore_a: assert property (rx_end && !flow_q[MPV_FLOW_RX_FC_BIT] |=> !RX_REJECT) // RQ6
		else $error("frame rejected with rx flow control off");
	halt_a: assert property (TX_PAUSED && st_q == MPV_TX_IDLE |=> st_q != MPV_TX_HEAD) // RQ7
		else $error("user frame started while paused");
	tag_bytes_a: assert property (st_q == MPV_TX_EMIT && cnt_q == 6'd0 && ins // RQ21
		|=> TX_OUT_DATA == tag_q[31:24] ##1 TX_OUT_DATA == tag_q[23:16]
		##1 TX_OUT_DATA == tag_q[15:8] ##1 TX_OUT_DATA == tag_q[7:0])
		else $error("inserted tag wrong");
	quanta_dec_a: assert property (!rx_hit && quanta_q != 16'h0000 && sub_q == 12'h000 // RQ25
		|=> quanta_q == $past(quanta_q) - 16'd1) else $error("quantum not counted");
	newfn_a: assert property (!newfn |-> !ins && !tx_xlate) // RQ10
		else $error("vlan function active without enable");
endmodule // mpv_core

// file: testbench/mpv_link_model.sv
// link partner model: sends rx frames, captures tx frames
// assumes the one clock and reset of the block under test
`timescale 1ns/10ps
module mpv_link_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic send,
	input wire logic [7:0] len,
	input wire logic [7:0] frm [64],
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic rx_last,
	output logic rx_good,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_last,
	output logic [7:0] cap [80],
	output logic [7:0] cap_len,
	output logic [7:0] prev_len,
	output logic [7:0] frames
);
	logic [7:0] rx_idx;
	logic [7:0] tx_idx;
	wire [7:0] nx = send ? 8'h00 : rx_idx;
	// rx sender; idle data toggles so stale bytes never look valid
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_idx <= 8'h00;
			rx_valid <= 1'b0;
			rx_last <= 1'b0;
			rx_good <= 1'b0;
			rx_data <= 8'h00;
		end else if (send || (rx_valid && !rx_last)) begin
			rx_valid <= 1'b1;
			rx_data <= frm[nx];
			rx_last <= (nx == len - 8'h01);
			rx_good <= (nx == len - 8'h01);
			rx_idx <= nx + 8'h01;
		end else begin
			rx_valid <= 1'b0;
			rx_last <= 1'b0;
			rx_good <= 1'b0;
			rx_data <= ~rx_data;
		end
	end
	// tx capture; keeps length of the last two frames
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_idx <= 8'h00;
			cap_len <= 8'h00;
			prev_len <= 8'h00;
			frames <= 8'h00;
		end else if (tx_valid) begin
			if (tx_idx < 8'd80) cap[tx_idx] <= tx_data;
			tx_idx <= tx_last ? 8'h00 : tx_idx + 8'h01;
			if (tx_last) begin
				prev_len <= cap_len;
				cap_len <= tx_idx + 8'h01;
				frames <= frames + 8'h01;
			end
		end
	end
endmodule // mpv_link_model

// file: testbench/tb_top.sv
// testbench top: register, pause and vlan scenarios
// assumes mpv_pkg, mpv_core and mpv_link_model compiled first
`timescale 1ns/10ps
module tb_top;
	import mpv_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [7:0] tx_in_data = 8'h00;
	logic tx_in_valid = 1'b0;
	logic tx_in_last = 1'b0;
	logic tx_in_ready, tx_out_valid, tx_out_last, rx_in_valid, rx_in_last, rx_in_good;
	logic rx_out_valid, rx_out_last, rx_out_bad, rx_reject, tx_paused, send = 1'b0;
	logic [7:0] tx_out_data, rx_in_data, rx_out_data, cap_len, prev_len, frames, rx_byte;
	logic [7:0] cap [80];
	logic [7:0] rxf [64];
	logic [7:0] txb [20];
	int fails = 0;
	int tests_run = 0;
	int rej_cnt = 0;
	int fwd_cnt = 0;
	mpv_core #(.TBL_DEPTH(16)) i_dut (.CLK(clk), .RESET(reset), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.TX_IN_DATA(tx_in_data), .TX_IN_VALID(tx_in_valid), .TX_IN_LAST(tx_in_last),
		.TX_IN_READY(tx_in_ready), .TX_OUT_DATA(tx_out_data), .TX_OUT_VALID(tx_out_valid),
		.TX_OUT_LAST(tx_out_last), .RX_IN_DATA(rx_in_data), .RX_IN_VALID(rx_in_valid),
		.RX_IN_LAST(rx_in_last), .RX_IN_GOOD(rx_in_good), .RX_OUT_DATA(rx_out_data),
		.RX_OUT_VALID(rx_out_valid), .RX_OUT_LAST(rx_out_last), .RX_OUT_BAD(rx_out_bad),
		.RX_REJECT(rx_reject), .TX_PAUSED(tx_paused));
	mpv_link_model i_link (.clk(clk), .reset(reset), .send(send), .len(8'd64), .frm(rxf),
		.rx_data(rx_in_data), .rx_valid(rx_in_valid), .rx_last(rx_in_last),
		.rx_good(rx_in_good), .tx_data(tx_out_data), .tx_valid(tx_out_valid),
		.tx_last(tx_out_last), .cap(cap), .cap_len(cap_len), .prev_len(prev_len),
		.frames(frames));
	always #10 clk = ~clk;
	// counts reject pulses and rx frames handed on as good
	always @(posedge clk) begin
		if (rx_reject === 1'b1) rej_cnt <= rej_cnt + 1;
		if (rx_out_valid === 1'b1) rx_byte <= rx_out_data;
		if (rx_out_valid === 1'b1 && rx_out_last === 1'b1 && rx_out_bad === 1'b0) fwd_cnt <= fwd_cnt + 1;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		chk(what, {24'h0, exp}, {24'h0, got});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
		@(posedge clk);
	endtask
	// byte stream with ready sampled where it settles before the edge
	task automatic tx_send(input int n);
		int i;
		logic tk;
		i = 0;
		while (i < n) begin
			tx_in_data <= txb[i];
			tx_in_last <= (i == n - 1);
			tx_in_valid <= 1'b1;
			@(negedge clk);
			tk = (tx_in_ready === 1'b1);
			@(posedge clk);
			if (tk) i++;
		end
		tx_in_valid <= 1'b0;
		tx_in_last <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_frames(input logic [7:0] k);
		int n;
		n = 0;
		while (frames !== k && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk8("tx frame count", k, frames);
	endtask
	// pause-shaped rx frame, 64 bytes with fcs, then a fixed settle gap
	task automatic rx_frame(input logic [15:0] v, input logic [15:0] op);
		for (int i = 0; i < 64; i++) rxf[i] = 8'h00;
		for (int i = 0; i < 6; i++) rxf[i] = MPV_PAUSE_DA[8*i +: 8];
		rxf[6] = 8'h02;
		{rxf[12], rxf[13], rxf[14], rxf[15]} = {MPV_PAUSE_TYPE, op};
		{rxf[16], rxf[17]} = v;
		rxf[63] = 8'h5A;
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		repeat (80) @(posedge clk);
	endtask
	task automatic t_regs;
		logic [31:0] d;
		rd(MPV_OFS_TPID_ZERO, d);
		chk("tpid zero reset", MPV_RST_TPID_ZERO, d);
		rd(MPV_OFS_TPID_ONE, d);
		chk("tpid one reset", MPV_RST_TPID_ONE, d);
		rd(8'hFC, d);
		chk("unmapped read", 32'h0, d);
		$display("test regs done");
	endtask
	task automatic t_pause_tx;
		logic [7:0] e [6] = '{8'h88, 8'h08, 8'h00, 8'h01, 8'h01, 8'h23};
		wr(MPV_OFS_RX_CONFIG_WORD_ZERO, 32'h4433_2211);
		wr(MPV_OFS_RX_CONFIG_WORD_ONE, 32'h4000_6655);
		wr(MPV_OFS_CTRL, 32'h0020_0000);
		wr(MPV_OFS_FLOW_CTRL_CONFIG, 32'h4000_0000);
		wr(MPV_OFS_TX_PAUSE, 32'h0000_0123);
		wait_frames(8'd1);
		chk8("pause length", 8'd60, cap_len);
		chk8("pause da first", 8'h11, cap[0]);
		chk8("pause da last", 8'h66, cap[5]);
		for (int i = 0; i < 6; i++) chk8("pause body", e[i], cap[12+i]);
		chk8("pause pad", 8'h00, cap[59]);
		$display("test pause_tx done");
	endtask
	task automatic t_pause_hold;
		for (int i = 0; i < 20; i++) txb[i] = 8'(i);
		{txb[12], txb[13]} = 16'h0800;
		fork
			tx_send(20);
			begin
				repeat (4) @(posedge clk);
				wr(MPV_OFS_TX_PAUSE, 32'h0000_0042);
			end
		join
		wait_frames(8'd3);
		chk8("user frame whole", 8'd20, prev_len);
		chk8("pause after frame", 8'h42, cap[17]);
		$display("test pause_hold done");
	endtask
	task automatic t_rx_pause;
		logic [31:0] d;
		int r0, f0;
		r0 = rej_cnt;
		f0 = fwd_cnt;
		wr(MPV_OFS_FLOW_CTRL_CONFIG, 32'h6000_0000);
		rx_frame(16'h0100, MPV_PAUSE_OPCODE);
		chk("reject pulse", r0 + 1, rej_cnt);
		chk("pause not forwarded", f0, fwd_cnt);
		chk8("tx halted", 8'h01, {7'h0, tx_paused});
		rd(MPV_OFS_STATUS, d);
		chk("status bits", 32'h1000_0001, d & 32'h1000_0001);
		wr(MPV_OFS_TX_PAUSE, 32'h0000_0007);
		wait_frames(8'd4);
		chk8("paused pause value", 8'h07, cap[17]);
		rx_frame(16'h0000, MPV_PAUSE_OPCODE);
		chk8("zero ends pause", 8'h00, {7'h0, tx_paused});
		$display("test rx_pause done");
	endtask
	task automatic t_rx_ignore;
		logic [31:0] fc [2] = '{32'h4000_0000, 32'h6000_0000};
		logic [15:0] op [2] = '{MPV_PAUSE_OPCODE, 16'h0002};
		int r0;
		int f0;
		for (int k = 0; k < 2; k++) begin
			r0 = rej_cnt;
			f0 = fwd_cnt;
			wr(MPV_OFS_FLOW_CTRL_CONFIG, fc[k]);
			rx_frame(16'h0050, op[k]);
			chk("no reject", r0, rej_cnt);
			chk("forwarded", f0 + 1, fwd_cnt);
			chk8("not halted", 8'h00, {7'h0, tx_paused});
			chk8("rx last byte", 8'h5A, rx_byte);
		end
		$display("test rx_ignore done");
	endtask
	task automatic t_vlan;
		logic [7:0] e [8] = '{8'h88, 8'hA8, 8'h01, 8'h23, 8'h81, 8'h00, 8'h00, 8'h0A};
		wr(MPV_OFS_CTRL, 32'h0021_4800);
		wr(MPV_OFS_TBL_INDEX, 32'h0000_0005);
		wr(MPV_OFS_TBL_DATA, 32'h0000_000A);
		wr(MPV_OFS_TX_TAG, 32'h88A8_0123);
		{txb[12], txb[13], txb[14], txb[15]} = 32'h8100_0005;
		tx_send(20);
		wait_frames(8'd5);
		chk8("tagged length", 8'd24, cap_len);
		for (int i = 0; i < 8; i++) chk8("tag and vid", e[i], cap[12+i]);
		chk8("body after tags", txb[16], cap[20]);
		$display("test vlan done");
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// main sequence after a 20-cycle reset
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_regs();
		t_pause_tx();
		t_pause_hold();
		t_rx_pause();
		t_rx_ignore();
		t_vlan();
		tally_and_finish();
	end
	// watchdog well beyond the several hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		tally_and_finish();
	end
endmodule // tb_top
